// *** logic/lou_pkg.sv ***
// package: constants, opcodes, register map and carriers of the low opcode execute unit
package lou_pkg;

	// ********************************************************************
	// word and address layout
	// ********************************************************************
	localparam int WORD_W = 8;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 4;
	localparam int OP_W = 6;
	localparam int OP_MSB = 7;
	localparam int OP_LSB = 2;
	localparam int DESIG_MSB = 1;
	localparam int PTR_W = 10;
	localparam logic [1:0] DESIG_NONE = 2'h0;
	localparam logic [1:0] DESIG_RETURN = 2'h1;
	localparam logic [1:0] DESIG_PAGE_IDX = 2'h3;
	localparam logic [ADDR_W-1:0] IRQ_VECTOR = 12'h001;
	localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;

	// ********************************************************************
	// opcodes, octal 00 to 15
	// ********************************************************************
	localparam logic [OP_W-1:0] OP_ERROR_STOP = 6'h00;
	localparam logic [OP_W-1:0] OP_ROTATE = 6'h01;
	localparam logic [OP_W-1:0] OP_ACC_TO_INDEX = 6'h02;
	localparam logic [OP_W-1:0] OP_INDEX_TO_ACC = 6'h03;
	localparam logic [OP_W-1:0] OP_LOAD_ENTRY = 6'h04;
	localparam logic [OP_W-1:0] OP_LOAD_EXIT = 6'h05;
	localparam logic [OP_W-1:0] OP_ENTRY_TO_ACC = 6'h06;
	localparam logic [OP_W-1:0] OP_CLEAR_CHANNEL = 6'h07;
	localparam logic [OP_W-1:0] OP_AND_IMM = 6'h08;
	localparam logic [OP_W-1:0] OP_AND_DIR = 6'h09;
	localparam logic [OP_W-1:0] OP_AND_IND = 6'h0a;
	localparam logic [OP_W-1:0] OP_RELEASE_LOCK = 6'h0b;
	localparam logic [OP_W-1:0] OP_OR_IMM = 6'h0c;
	localparam logic [OP_W-1:0] OP_OR_DIR = 6'h0d;

	// ********************************************************************
	// register map, byte addresses
	// ********************************************************************
	localparam int RA_W = 8;
	localparam logic [RA_W-1:0] REG_CTRL = 8'h00;
	localparam logic [RA_W-1:0] REG_STATUS = 8'h04;
	localparam logic [RA_W-1:0] REG_ACC = 8'h08;
	localparam logic [RA_W-1:0] REG_PC = 8'h0c;
	localparam logic [RA_W-1:0] REG_INDEX = 8'h10;
	localparam logic [RA_W-1:0] REG_ENTRY = 8'h14;
	localparam logic [RA_W-1:0] REG_EXIT = 8'h18;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ********************************************************************
	// carriers
	// ********************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_WORD2,
		ST_POINTER,
		ST_OPERAND,
		ST_EXEC
	} lou_state_type;

	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
	} lou_mem_req_type;

	typedef struct packed {
		logic running;
		logic irq_lock;
		logic bad_opcode;
		logic error_stop;
	} lou_status_type;

endpackage

// *** logic/lou_low_opcode_execute_unit.sv ***
// low opcode execute unit: fetch, decode and execute of opcodes 00 to 15 with an ahb-lite register port
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

module lou_low_opcode_execute_unit (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output lou_pkg::lou_mem_req_type mem_out,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	input wire logic buf_busy,
	output logic buf_ctrl_clear,
	output logic [9:0] buffer_entry_pointer,
	output logic [7:0] buffer_exit_pointer,
	input wire logic irq_request,
	output lou_pkg::lou_status_type status
);

	// ********************************************************************
	// decode helpers
	// ********************************************************************
	function automatic logic two_word(input logic [lou_pkg::OP_W-1:0] op);
		two_word = (op == lou_pkg::OP_LOAD_ENTRY) || (op == lou_pkg::OP_LOAD_EXIT) ||
			(op == lou_pkg::OP_AND_IMM) || (op == lou_pkg::OP_AND_DIR) ||
			(op == lou_pkg::OP_AND_IND) || (op == lou_pkg::OP_OR_IMM) ||
			(op == lou_pkg::OP_OR_DIR);
	endfunction

	function automatic logic known_op(input logic [lou_pkg::OP_W-1:0] op);
		known_op = op <= lou_pkg::OP_OR_DIR;
	endfunction

	// ********************************************************************
	// state
	// ********************************************************************
	lou_pkg::lou_state_type state_ff, nxt_state;
	logic [lou_pkg::ADDR_W-1:0] pc_ff, nxt_pc, ret_ff, nxt_ret;
	logic [lou_pkg::WORD_W-1:0] acc_ff, nxt_acc, ir_ff, nxt_ir, w2_ff, nxt_w2, ptr_ff, nxt_ptr;
	logic [lou_pkg::PTR_W-1:0] entry_ff, nxt_entry;
	logic [lou_pkg::WORD_W-1:0] exit_ff, nxt_exit;
	logic lock_ff, nxt_lock, err_ff, nxt_err, bad_ff, nxt_bad, stop_ff, nxt_stop, clr_ff, nxt_clr;
	logic [lou_pkg::IDX_W-1:0] idx_ff [1:3];
	logic [lou_pkg::IDX_W-1:0] nxt_idx [1:3];
	logic [3:1] idx_we;
	logic [lou_pkg::IDX_W-1:0] idx_wdata;

	// ********************************************************************
	// ahb-lite slave, zero wait states
	// ********************************************************************
	logic wr_pend_ff;
	logic [lou_pkg::RA_W-1:0] wr_addr_ff;
	logic [31:0] rdata_ff, rd_mux;
	wire ahb_go = hsel && hready && (htrans == lou_pkg::HTRANS_NONSEQ);
	wire [lou_pkg::RA_W-1:0] ra = haddr[lou_pkg::RA_W-1:0];
	wire idle = (state_ff == lou_pkg::ST_IDLE);
	wire wr_ctrl = wr_pend_ff && (wr_addr_ff == lou_pkg::REG_CTRL);
	wire sw_start = wr_ctrl && hwdata[lou_pkg::CTRL_START_BIT] && idle;
	wire sw_stop = wr_ctrl && hwdata[lou_pkg::CTRL_STOP_BIT];
	wire sw_acc = wr_pend_ff && idle && (wr_addr_ff == lou_pkg::REG_ACC);
	wire sw_pc = wr_pend_ff && idle && (wr_addr_ff == lou_pkg::REG_PC);
	wire sw_idx = wr_pend_ff && idle && (wr_addr_ff == lou_pkg::REG_INDEX);

	always_comb begin
		if (ra == lou_pkg::REG_STATUS) begin
			rd_mux = {28'h0000000, status};
		end else if (ra == lou_pkg::REG_ACC) begin
			rd_mux = {24'h000000, acc_ff};
		end else if (ra == lou_pkg::REG_PC) begin
			rd_mux = {20'h00000, pc_ff};
		end else if (ra == lou_pkg::REG_INDEX) begin
			rd_mux = {20'h00000, idx_ff[3], idx_ff[2], idx_ff[1]};
		end else if (ra == lou_pkg::REG_ENTRY) begin
			rd_mux = {22'h000000, entry_ff};
		end else if (ra == lou_pkg::REG_EXIT) begin
			rd_mux = {24'h000000, exit_ff};
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rdata_ff <= 32'h00000000;
		end else begin
			wr_pend_ff <= ahb_go && hwrite;
			wr_addr_ff <= ahb_go ? ra : wr_addr_ff;
			rdata_ff <= (ahb_go && !hwrite) ? rd_mux : rdata_ff;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_ff;

	// ********************************************************************
	// decode and address forming
	// ********************************************************************
	wire [lou_pkg::OP_W-1:0] op = ir_ff[lou_pkg::OP_MSB:lou_pkg::OP_LSB];
	wire [1:0] desig = ir_ff[lou_pkg::DESIG_MSB:0];
	wire indexed = (desig != lou_pkg::DESIG_NONE);
	wire [lou_pkg::IDX_W-1:0] idx_sel = indexed ? idx_ff[desig] : 4'h0;
	// index nibble above an 8-bit low part
	wire [lou_pkg::WORD_W-1:0] low_part = (op == lou_pkg::OP_AND_IND) ? ptr_ff : w2_ff;
	wire [lou_pkg::ADDR_W-1:0] combined = {idx_sel, low_part};
	wire [lou_pkg::ADDR_W-1:0] branch_addr = {idx_sel, w2_ff};
	wire mem_phase = (state_ff == lou_pkg::ST_FETCH) || (state_ff == lou_pkg::ST_WORD2) ||
		(state_ff == lou_pkg::ST_POINTER) || (state_ff == lou_pkg::ST_OPERAND);
	wire [lou_pkg::OP_W-1:0] fetch_op = mem_rdata[lou_pkg::OP_MSB:lou_pkg::OP_LSB];

	always_comb begin
		if (state_ff == lou_pkg::ST_POINTER) begin
			// pointer comes from the first 256 words
			mem_out.addr = {4'h0, w2_ff};
		end else if (state_ff == lou_pkg::ST_OPERAND) begin
			mem_out.addr = combined;
		end else begin
			mem_out.addr = pc_ff;
		end
		mem_out.req = mem_phase;
	end

	// ********************************************************************
	// sequencer and execution
	// ********************************************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_pc = pc_ff;
		nxt_ret = ret_ff;
		nxt_acc = acc_ff;
		nxt_ir = ir_ff;
		nxt_w2 = w2_ff;
		nxt_ptr = ptr_ff;
		nxt_entry = entry_ff;
		nxt_exit = exit_ff;
		nxt_lock = lock_ff;
		nxt_err = err_ff;
		nxt_bad = bad_ff;
		nxt_stop = stop_ff || sw_stop;
		nxt_clr = 1'b0;
		idx_we = 3'h0;
		idx_wdata = acc_ff[lou_pkg::IDX_W-1:0];
		case (state_ff)
			lou_pkg::ST_IDLE: begin
				nxt_stop = 1'b0;
				if (sw_acc) begin
					nxt_acc = hwdata[lou_pkg::WORD_W-1:0];
				end
				if (sw_pc) begin
					nxt_pc = hwdata[lou_pkg::ADDR_W-1:0];
				end
				if (sw_start) begin
					nxt_err = 1'b0;
					nxt_bad = 1'b0;
					nxt_state = lou_pkg::ST_FETCH;
				end
			end
			lou_pkg::ST_FETCH: begin
				if (mem_ack) begin
					nxt_ir = mem_rdata;
					nxt_pc = pc_ff + 12'h001;
					nxt_state = two_word(fetch_op) ? lou_pkg::ST_WORD2 : lou_pkg::ST_EXEC;
				end
			end
			lou_pkg::ST_WORD2: begin
				if (mem_ack) begin
					// second word follows, pc steps past it
					nxt_w2 = mem_rdata;
					nxt_pc = pc_ff + 12'h001;
					if (op == lou_pkg::OP_AND_IND) begin
						nxt_state = lou_pkg::ST_POINTER;
					end else if ((op == lou_pkg::OP_AND_DIR) || (op == lou_pkg::OP_OR_DIR)) begin
						nxt_state = lou_pkg::ST_OPERAND;
					end else begin
						nxt_state = lou_pkg::ST_EXEC;
					end
				end
			end
			lou_pkg::ST_POINTER: begin
				if (mem_ack) begin
					nxt_ptr = mem_rdata;
					nxt_state = lou_pkg::ST_OPERAND;
				end
			end
			lou_pkg::ST_OPERAND: begin
				// memory is only read here, never written back
				if (mem_ack) begin
					nxt_w2 = mem_rdata;
					nxt_state = lou_pkg::ST_EXEC;
				end
			end
			default: begin
				nxt_state = lou_pkg::ST_FETCH;
				case (op)
					lou_pkg::OP_ERROR_STOP: begin
						nxt_err = 1'b1;
						nxt_state = lou_pkg::ST_IDLE;
					end
					lou_pkg::OP_ROTATE: begin
						nxt_acc = {acc_ff[lou_pkg::WORD_W-2:0], acc_ff[lou_pkg::WORD_W-1]};
					end
					lou_pkg::OP_ACC_TO_INDEX: begin
						// low nibble into the designated index
						if (indexed) begin
							idx_we[desig] = 1'b1;
						end
					end
					lou_pkg::OP_INDEX_TO_ACC: begin
						nxt_acc = {4'h0, idx_sel};
					end
					lou_pkg::OP_LOAD_ENTRY, lou_pkg::OP_LOAD_EXIT: begin
						// page bits from index register 3
						if (op == lou_pkg::OP_LOAD_ENTRY) begin
							nxt_entry = {idx_ff[lou_pkg::DESIG_PAGE_IDX][1:0], acc_ff};
						end else begin
							nxt_exit = acc_ff;
						end
						// busy channel branches to combined address
						if (buf_busy) begin
							nxt_pc = branch_addr;
						end
					end
					lou_pkg::OP_ENTRY_TO_ACC: begin
						nxt_acc = entry_ff[lou_pkg::WORD_W-1:0];
					end
					lou_pkg::OP_CLEAR_CHANNEL: begin
						// one-cycle clear to the channel control
						nxt_clr = 1'b1;
					end
					lou_pkg::OP_AND_IMM, lou_pkg::OP_AND_DIR, lou_pkg::OP_AND_IND: begin
						nxt_acc = acc_ff & w2_ff;
					end
					lou_pkg::OP_RELEASE_LOCK: begin
						nxt_lock = 1'b0;
						// designation 1 resumes the main program
						if (desig == lou_pkg::DESIG_RETURN) begin
							nxt_pc = ret_ff;
						end
					end
					lou_pkg::OP_OR_IMM, lou_pkg::OP_OR_DIR: begin
						nxt_acc = acc_ff | w2_ff;
					end
					default: begin
						// opcodes above 15 belong to other units; stop rather than guess
						nxt_bad = 1'b1;
						nxt_state = lou_pkg::ST_IDLE;
					end
				endcase
				if (nxt_state == lou_pkg::ST_FETCH) begin
					if (nxt_stop) begin
						nxt_state = lou_pkg::ST_IDLE;
					end else if (irq_request && !nxt_lock) begin
						// interrupts are taken only between instructions
						nxt_ret = nxt_pc;
						nxt_pc = lou_pkg::IRQ_VECTOR;
						nxt_lock = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= lou_pkg::ST_IDLE;
			pc_ff <= lou_pkg::PC_RESET;
			ret_ff <= lou_pkg::PC_RESET;
			acc_ff <= 8'h00;
			ir_ff <= 8'h00;
			w2_ff <= 8'h00;
			ptr_ff <= 8'h00;
			entry_ff <= 10'h000;
			exit_ff <= 8'h00;
			lock_ff <= 1'b0;
			err_ff <= 1'b0;
			bad_ff <= 1'b0;
			stop_ff <= 1'b0;
			clr_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pc_ff <= nxt_pc;
			ret_ff <= nxt_ret;
			acc_ff <= nxt_acc;
			ir_ff <= nxt_ir;
			w2_ff <= nxt_w2;
			ptr_ff <= nxt_ptr;
			entry_ff <= nxt_entry;
			exit_ff <= nxt_exit;
			lock_ff <= nxt_lock;
			err_ff <= nxt_err;
			bad_ff <= nxt_bad;
			stop_ff <= nxt_stop;
			clr_ff <= nxt_clr;
		end
	end

	// ********************************************************************
	// index registers 1 to 3
	// ********************************************************************
	genvar gi;
	generate
		for (gi = 1; gi <= 3; gi++) begin : g_idx
			// software loads all three at once while idle
			assign nxt_idx[gi] = sw_idx ? hwdata[gi*4-1 -: 4] : (idx_we[gi] ? idx_wdata : idx_ff[gi]);
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					idx_ff[gi] <= 4'h0;
				end else begin
					idx_ff[gi] <= nxt_idx[gi];
				end
			end
		end
	endgenerate

	// ********************************************************************
	// outputs
	// ********************************************************************
	assign buf_ctrl_clear = clr_ff;
	assign buffer_entry_pointer = entry_ff;
	// software must load last address plus 1 or 2 here
	assign buffer_exit_pointer = exit_ff;
	assign status.running = !idle;
	// lock stays set until the routine releases it
	assign status.irq_lock = lock_ff;
	assign status.bad_opcode = bad_ff;
	assign status.error_stop = err_ff;

endmodule

// *** testbench/lou_unit_props.sv ***
// checker: port-level properties of the low opcode execute unit
`timescale 1ns/1ps

module lou_unit_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input lou_pkg::lou_mem_req_type mem_out,
	input wire logic mem_ack,
	input wire logic buf_ctrl_clear,
	input wire logic [9:0] buffer_entry_pointer,
	input wire logic [7:0] buffer_exit_pointer,
	input lou_pkg::lou_status_type status
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ********************************************************************
	// sequences
	// ********************************************************************
	sequence s_read_done;
		mem_out.req && mem_ack;
	endsequence
	sequence s_exec;
		s_read_done ##1 !mem_out.req;
	endsequence
	// ********************************************************************
	// properties
	// ********************************************************************
	AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	AST_REQ_HOLD: assert property (mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr))
		else $error("memory request dropped or moved before ack");
	AST_IDLE_QUIET: assert property (!status.running |-> !mem_out.req) else $error("request while idle");
	AST_ERR_HALTS: assert property (status.error_stop |-> !status.running) else $error("running after error stop");
	AST_EXEC_ONE: assert property (s_exec |=> mem_out.req || !status.running) else $error("execute longer than one cycle");
	AST_CLR_PULSE: assert property (buf_ctrl_clear |=> !buf_ctrl_clear) else $error("clear pulse too long");
	AST_CLR_AFTER_EXEC: assert property (buf_ctrl_clear |-> $past(!mem_out.req)) else $error("clear not after execute");
	AST_ENTRY_AT_EXEC: assert property ($changed(buffer_entry_pointer) |-> $past(!mem_out.req && status.running))
		else $error("entry pointer changed outside execute");
	AST_EXIT_AT_EXEC: assert property ($changed(buffer_exit_pointer) |-> $past(!mem_out.req && status.running))
		else $error("exit pointer changed outside execute");
	AST_IRQ_VECTOR: assert property ($rose(status.irq_lock) |-> mem_out.req && mem_out.addr == lou_pkg::IRQ_VECTOR)
		else $error("interrupt not vectored");
endmodule

bind lou_low_opcode_execute_unit lou_unit_props u_props (.hclk, .hresetn, .hreadyout, .hresp, .mem_out, .mem_ack,
	.buf_ctrl_clear, .buffer_entry_pointer, .buffer_exit_pointer, .status);

// *** testbench/lou_core_model.sv ***
// partner: core memory and buffer channel controller
`timescale 1ns/1ps

module lou_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input lou_pkg::lou_mem_req_type mem_out,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	input wire logic [3:0] delay,
	input wire logic busy_set,
	input wire logic buf_ctrl_clear,
	output logic buf_busy
);
	logic [7:0] mem [4096];
	logic [3:0] wait_ff;
	logic [7:0] last_ff;
	logic busy_ff;
	initial begin
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	// read only core
	// operands are never written back, so memory stays unchanged
	assign mem_ack = mem_out.req && (wait_ff >= delay);
	// undriven data toggles so a stale sample never looks valid
	assign mem_rdata = mem_ack ? mem[mem_out.addr] : ~last_ff;
	assign buf_busy = busy_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_ff <= 4'h0;
			last_ff <= 8'h00;
			busy_ff <= 1'b0;
		end else begin
			wait_ff <= (mem_out.req && !mem_ack) ? wait_ff + 4'h1 : 4'h0;
			last_ff <= mem_rdata;
			if (busy_set)
				busy_ff <= 1'b1;
			else if (buf_ctrl_clear)
				busy_ff <= 1'b0;
		end
	end
endmodule

// *** testbench/tb.sv ***
// testbench: runs short programs through the execute unit over its register port
`timescale 1ns/1ps

module tb;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	lou_pkg::lou_mem_req_type mem_out;
	lou_pkg::lou_status_type status;
	logic mem_ack, buf_busy, buf_ctrl_clear, irq_request, busy_set;
	logic [7:0] mem_rdata, buffer_exit_pointer;
	logic [9:0] buffer_entry_pointer;
	logic [3:0] mem_delay;
	int errors, checks_done, cycles;
	assign hready = hreadyout;
	lou_low_opcode_execute_unit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .buf_busy(buf_busy),
		.buf_ctrl_clear(buf_ctrl_clear), .buffer_entry_pointer(buffer_entry_pointer),
		.buffer_exit_pointer(buffer_exit_pointer), .irq_request(irq_request), .status(status));
	lou_core_model u_mem (.hclk(hclk), .hresetn(hresetn), .mem_out(mem_out), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .delay(mem_delay), .busy_set(busy_set), .buf_ctrl_clear(buf_ctrl_clear),
		.buf_busy(buf_busy));
	// ********************************************************************
	// tasks
	// ********************************************************************
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wt();
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= lou_pkg::HTRANS_NONSEQ;
		wt();
		htrans <= 2'h0;
		hwdata <= wd;
		wt();
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(d, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		ahb(1'b1, a, wd, d);
	endtask
	task automatic put(input logic [11:0] a, input logic [7:0] w[$]);
		foreach (w[i])
			u_mem.mem[a + i] = w[i];
	endtask
	// start at pc and poll until the program halts
	task automatic run(input logic [11:0] pc);
		logic [31:0] d;
		wr(lou_pkg::REG_PC, {20'h0, pc});
		wr(lou_pkg::REG_CTRL, 32'h1);
		do ahb(1'b0, lou_pkg::REG_STATUS, 32'h0, d); while (d[3] !== 1'b0);
	endtask
	// ********************************************************************
	// clock, timeout, interrupt source
	// ********************************************************************
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			conclude();
		end
		// source drops once the routine is entered
		if (status.irq_lock === 1'b1)
			irq_request <= 1'b0;
	end
	// ********************************************************************
	// tests
	// ********************************************************************
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hsize = 3'h2;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		irq_request = 1'b0;
		busy_set = 1'b0;
		mem_delay = 4'h3;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(lou_pkg::REG_STATUS, 32'h0);
		rdc(lou_pkg::REG_ENTRY, 32'h0);
		rdc(8'h40, 32'h0);
		// arithmetic and transfers, slow memory
		put(12'h100, '{8'h04, 8'h08, 8'h30, 8'hf0, 8'h20, 8'h3c, 8'h35, 8'h10, 8'h26, 8'h20, 8'h29, 8'h40,
			8'h0b, 8'h0e, 8'h10, 8'h00, 8'h14, 8'h00, 8'h04, 8'h18, 8'h00});
		put(12'h210, '{8'h05});
		put(12'ha20, '{8'h1d});
		put(12'h040, '{8'h80});
		put(12'h280, '{8'h0f});
		wr(lou_pkg::REG_ACC, 32'h81);
		wr(lou_pkg::REG_INDEX, 32'hea2);
		run(12'h100);
		rdc(lou_pkg::REG_ACC, 32'h0a);
		rdc(lou_pkg::REG_INDEX, 32'h5a2);
		rdc(lou_pkg::REG_ENTRY, 32'h10a);
		rdc(lou_pkg::REG_EXIT, 32'h0a);
		rdc(lou_pkg::REG_STATUS, 32'h1);
		rdc(lou_pkg::REG_PC, 32'h115);
		// index to accumulator without index, lock release without return, unknown opcode stops; prompt memory
		mem_delay <= 4'h0;
		put(12'h300, '{8'h0c, 8'h2c, 8'h40});
		wr(lou_pkg::REG_ACC, 32'hff);
		run(12'h300);
		rdc(lou_pkg::REG_ACC, 32'h0);
		rdc(lou_pkg::REG_PC, 32'h303);
		rdc(lou_pkg::REG_STATUS, 32'h2);
		// busy channel: both pointer loads branch, channel clear drops busy
		wr(lou_pkg::REG_ACC, 32'h31);
		put(12'h320, '{8'h15, 8'h40});
		put(12'h240, '{8'h11, 8'h60});
		put(12'h260, '{8'h1c, 8'h00});
		busy_set <= 1'b1;
		@(posedge hclk);
		busy_set <= 1'b0;
		run(12'h320);
		rdc(lou_pkg::REG_PC, 32'h262);
		rdc(lou_pkg::REG_ENTRY, 32'h131);
		rdc(lou_pkg::REG_EXIT, 32'h31);
		chk({31'h0, buf_busy}, 32'h0);
		chk({22'h0, buffer_entry_pointer}, 32'h131);
		chk({24'h0, buffer_exit_pointer}, 32'h31);
		// interrupt routine releases the lock and returns
		put(12'h330, '{8'h04, 8'h00});
		put(12'h001, '{8'h2d, 8'h00});
		wr(lou_pkg::REG_ACC, 32'h40);
		irq_request <= 1'b1;
		run(12'h330);
		rdc(lou_pkg::REG_PC, 32'h332);
		rdc(lou_pkg::REG_STATUS, 32'h1);
		rdc(lou_pkg::REG_ACC, 32'h80);
		conclude();
	end
endmodule
